// [design/nspw_serial_port.sv]
// NRZ serial port: transmitter, oversampling receiver, sync clock and wake-up
`timescale 1ns/1ps
`default_nettype none

module nspw_serial_port
	import nspw_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// Data window: write port and received data
	input  wire logic       dataWr,
	input  wire logic [7:0] dataWrVal,
	input  wire logic       txBit8,
	output logic      [7:0] rxData,
	output logic            rxBit8,
	// Control one
	input  wire logic       wordNine,
	input  wire logic       wakeAddr,
	input  wire logic       clkPol,
	input  wire logic       clkPha,
	input  wire logic       lastBitClk,
	// Control two
	input  wire logic       txOn,
	input  wire logic       rxOn,
	input  wire logic       txIrqEn,
	input  wire logic       doneIrqEn,
	input  wire logic       rxIrqEn,
	input  wire logic       idleIrqEn,
	input  wire logic       sleepSetReq,
	input  wire logic       sleepClrReq,
	input  wire logic       breakSend,
	// Rate selects
	input  wire logic [1:0] prescaleSel,
	input  wire logic [2:0] rxRateSel,
	input  wire logic [2:0] txRateSel,
	// Flags
	input  wire logic       rxFlagsAck,
	output logic            txEmpty,
	output logic            txDone,
	output logic            rxFull,
	output logic            lineQuiet,
	output logic            overrun,
	output logic            noise,
	output logic            framingErr,
	output logic            rxSleep,
	output logic            irq,
	// Serial pins
	input  wire logic       serialIn,
	output logic            serialOut,
	output logic            serialOutEn,
	output logic            syncClk,
	output logic            syncClkEn
);
	import nspw_pkg::*;

	typedef struct packed {
		logic        inSync1;
		logic        inSync2;
		logic [1:0]  preCnt;
		logic [6:0]  rxDiv;
		logic [6:0]  txDiv;
		logic [3:0]  txSub;
		nspw_rx_e    rxSt;
		logic [3:0]  rxRt;
		logic [3:0]  rxIdx;
		logic [2:0]  rxSamp;
		logic [8:0]  rxShift;
		logic        rxNoise;
		logic [7:0]  quietCnt;
		logic        gotChar;
		logic [7:0]  rxData;
		logic        rxBit8;
		logic        rxFull;
		logic        overrun;
		logic        noise;
		logic        framingErr;
		logic        lineQuiet;
		logic        rxSleep;
		nspw_tx_e    txSt;
		logic [8:0]  txBuf;
		logic        bufFull;
		logic [10:0] txShift;
		logic [3:0]  txLeft;
		logic [3:0]  txIdx;
		logic        txData;
		logic        txLine;
		logic        txEmpty;
		logic        txDone;
		logic        preamblePend;
		logic        prevTxOn;
		logic        syncClk;
	} nspw_state_s;

	nspw_state_s s;
	nspw_state_s n;

	logic        preTick;
	logic        rxTick;
	logic        txTick;
	logic        bitTick;
	logic        line;
	logic        vote;
	logic        disagree;
	logic        frameEnd;
	logic        loadData;
	logic        loadAny;
	logic        wakeNow;
	logic        syncAct;
	logic [10:0] dataFrame;
	logic [7:0]  quietLim;

	always_comb begin
		n = s;
		n.inSync1 = serialIn;
		n.inSync2 = s.inSync1;
		line = s.inSync2;

		// Shared prescaler, then independent power-of-two rate selects
		preTick = (s.preCnt == prescaleSel);
		n.preCnt = preTick ? 2'h0 : s.preCnt + 2'h1;
		n.rxDiv = preTick ? s.rxDiv + 7'h01 : s.rxDiv;
		n.txDiv = preTick ? s.txDiv + 7'h01 : s.txDiv;
		rxTick = preTick && ((s.rxDiv & rateMask(rxRateSel)) == rateMask(rxRateSel));
		txTick = preTick && ((s.txDiv & rateMask(txRateSel)) == rateMask(txRateSel));
		// Transmit bit tick is one sixteenth of the transmit rate tick (txTick)
		n.txSub = txTick ? s.txSub + 4'h1 : s.txSub;
		bitTick = txTick && (s.txSub == TX_SUB_LAST);

		// Receive flag clears come first so that a same-cycle set wins; a same-cycle sleep clear beats a sleep set
		if (rxFlagsAck) begin
			n.rxFull = 1'b0;
			n.overrun = 1'b0;
			n.noise = 1'b0;
			n.framingErr = 1'b0;
			n.lineQuiet = 1'b0;
		end
		if (sleepSetReq) begin
			n.rxSleep = 1'b1;
		end
		if (sleepClrReq) begin
			n.rxSleep = 1'b0;
		end

		// Receiver
		vote = maj3(s.rxSamp);
		disagree = (|s.rxSamp) && !(&s.rxSamp);
		wakeNow = s.rxSleep && wakeAddr && s.rxShift[8];
		quietLim = wordNine ? QUIET_RT_9 : QUIET_RT_8;
		if (!rxOn) begin
			n.rxSt = RX_HUNT;
			n.quietCnt = 8'h00;
		end else if (rxTick) begin
			// Quiet counter runs only between frames while the line stays high
			if (line && s.rxSt == RX_HUNT && s.quietCnt != quietLim) begin
				n.quietCnt = s.quietCnt + 8'h01;
				if (s.quietCnt + 8'h01 == quietLim) begin
					if (s.rxSleep && !wakeAddr) begin
						n.rxSleep = 1'b0;
					end else if (!s.rxSleep && s.gotChar) begin
						n.lineQuiet = 1'b1;
						n.gotChar = 1'b0;
					end
				end
			end else if (!line || s.rxSt == RX_FRAME) begin
				n.quietCnt = 8'h00;
			end
			case (s.rxSt)
				RX_HUNT: begin
					if (!line) begin
						n.rxSt = RX_FRAME;
						n.rxRt = 4'h0;
						n.rxIdx = IDX_START;
						n.rxNoise = 1'b0;
					end
				end
				RX_FRAME: begin
					n.rxRt = s.rxRt + 4'h1;
					if (s.rxRt == RT_LAST) begin
						n.rxIdx = s.rxIdx + 4'h1;
					end
					if (s.rxRt == RT_SAMPLE_A || s.rxRt == RT_SAMPLE_B || s.rxRt == RT_SAMPLE_C) begin
						n.rxSamp = {s.rxSamp[1:0], line};
					end
					if (s.rxRt == RT_VOTE) begin
						n.rxNoise = s.rxNoise | disagree;
						if (s.rxIdx == IDX_START) begin
							if (vote) begin
								n.rxSt = RX_HUNT;
							end
						end else if (s.rxIdx <= dataBits(wordNine)) begin
							n.rxShift = {vote, s.rxShift[8:1]};
						end else begin
							// Stop bit: a low stop, all-zero data included, is a framing error
							n.rxSt = RX_HUNT;
							if (!s.rxSleep || wakeNow) begin
								n.gotChar = 1'b1;
								n.noise = n.noise | s.rxNoise | disagree;
								n.framingErr = n.framingErr | !vote;
								if (s.rxFull) begin
									n.overrun = 1'b1;
								end else begin
									n.rxFull = 1'b1;
									n.rxData = wordNine ? s.rxShift[7:0] : s.rxShift[8:1];
									n.rxBit8 = wordNine & s.rxShift[8];
								end
							end
							if (wakeNow) begin
								n.rxSleep = 1'b0;
							end
						end
					end
				end
				default: n.rxSt = RX_HUNT;
			endcase
		end

		// Transmitter
		n.prevTxOn = txOn;
		if (txOn && !s.prevTxOn) begin
			n.preamblePend = 1'b1;
		end
		if (dataWr) begin
			n.txBuf = {txBit8, dataWrVal};
			n.bufFull = 1'b1;
			n.txEmpty = 1'b0;
			n.txDone = 1'b0;
		end
		dataFrame = {1'b1, wordNine ? s.txBuf[8] : 1'b1, s.txBuf[7:0], 1'b0};
		frameEnd = (s.txSt == TX_IDLE) || (s.txLeft == 4'h1);
		loadData = bitTick && frameEnd && txOn && !s.preamblePend && s.bufFull;
		loadAny = bitTick && frameEnd && txOn && (s.preamblePend || s.bufFull || breakSend);
		if (bitTick) begin
			if (!frameEnd) begin
				n.txShift = {1'b1, s.txShift[10:1]};
				n.txLine = s.txShift[1];
				n.txLeft = s.txLeft - 4'h1;
				n.txIdx = s.txIdx + 4'h1;
			end else if (loadAny) begin
				// A frame in flight always completes; only new loads need the enable
				n.txSt = TX_FRAME;
				n.txLeft = frameBits(wordNine);
				n.txIdx = IDX_START;
				n.txData = loadData;
				if (s.preamblePend) begin
					n.txShift = FRAME_ONES;
					n.preamblePend = 1'b0;
				end else if (s.bufFull) begin
					n.txShift = dataFrame;
					n.bufFull = dataWr;
					n.txEmpty = 1'b1;
				end else begin
					n.txShift = FRAME_ZEROS;
				end
				n.txLine = n.txShift[0];
			end else begin
				n.txSt = TX_IDLE;
				n.txLine = 1'b1;
				if (s.txSt == TX_FRAME) begin
					n.txDone = 1'b1;
				end
			end
		end

		// Sync clock: data bits only, last one on request, preamble and break silent
		syncAct = (s.txSt == TX_FRAME) && s.txData && (s.txIdx >= IDX_FIRST)
			&& ((s.txIdx < dataBits(wordNine)) || (s.txIdx == dataBits(wordNine) && lastBitClk));
		n.syncClk = clkPol ^ (syncAct && (clkPha ^ s.txSub[TX_HALF_BIT]));

		if (sys_rst) begin
			n = '0;
			n.txEmpty = TX_EMPTY_RST;
			n.txDone = TX_DONE_RST;
			n.txLine = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		s <= n;
	end

	assign rxData = s.rxData;
	assign rxBit8 = s.rxBit8;
	assign txEmpty = s.txEmpty;
	assign txDone = s.txDone;
	assign rxFull = s.rxFull;
	assign lineQuiet = s.lineQuiet;
	assign overrun = s.overrun;
	assign noise = s.noise;
	assign framingErr = s.framingErr;
	assign rxSleep = s.rxSleep;
	assign irq = (txIrqEn && s.txEmpty) || (doneIrqEn && s.txDone)
		|| (rxIrqEn && (s.rxFull || s.overrun)) || (idleIrqEn && s.lineQuiet);
	assign serialOut = s.txLine;
	assign serialOutEn = txOn || (s.txSt == TX_FRAME);
	assign syncClk = s.syncClk;
	assign syncClkEn = serialOutEn;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence dataLoadSeq;
		loadData;
	endsequence

	sequence idleTwoSeq;
		(s.txSt == TX_IDLE && $stable(clkPol)) [*2];
	endsequence

	start_bit_low_a: assert property (
		s.txSt == TX_FRAME && s.txData && s.txIdx == IDX_START |-> !serialOut)
		else $error("data frame start bit not low");
	stop_bit_high_a: assert property (
		s.txSt == TX_FRAME && s.txData && s.txLeft == 4'h1 |-> serialOut)
		else $error("data frame stop bit not high");
	lsb_first_a: assert property (
		dataLoadSeq |=> s.txShift[1] == $past(s.txBuf[0]))
		else $error("first data bit is not the lsb");
	empty_on_load_a: assert property (
		dataLoadSeq |=> txEmpty && s.txSt == TX_FRAME)
		else $error("empty flag not set on shifter load");
	done_at_end_a: assert property (
		bitTick && s.txSt == TX_FRAME && s.txLeft == 4'h1 && !loadAny |=> txDone && s.txSt == TX_IDLE)
		else $error("done flag not set at end of frame");
	finish_char_a: assert property (
		!txOn && s.txSt == TX_FRAME && !(bitTick && s.txLeft == 4'h1) |=> s.txSt == TX_FRAME)
		else $error("frame cut short when transmitter switched off");
	hiz_when_off_a: assert property (
		!txOn && s.txSt == TX_IDLE |-> !serialOutEn && !syncClkEn)
		else $error("pins driven with transmitter off");
	sleep_blocks_flags_a: assert property (
		s.rxSleep && !wakeAddr && !rxFull && !lineQuiet |=> !rxFull && !lineQuiet)
		else $error("receive flag set while asleep");
	idle_irq_a: assert property (
		idleIrqEn && lineQuiet |-> irq)
		else $error("idle interrupt missing");
	sync_rest_a: assert property (
		idleTwoSeq |-> syncClk == clkPol)
		else $error("sync clock not at rest level");
endmodule

`default_nettype wire

// [pkg/nspw_pkg.sv]
// Shared constants, types and helpers for the NRZ serial port with wake-up
package nspw_pkg;
	// Receiver oversampling: zero-based slot numbers inside one bit
	localparam logic [3:0] RT_SAMPLE_A  = 4'h7;
	localparam logic [3:0] RT_SAMPLE_B  = 4'h8;
	localparam logic [3:0] RT_SAMPLE_C  = 4'h9;
	localparam logic [3:0] RT_VOTE      = 4'ha;
	localparam logic [3:0] RT_LAST      = 4'hf;
	// Transmitter divide-by-sixteen stage
	localparam logic [3:0] TX_SUB_LAST  = 4'hf;
	localparam int         TX_HALF_BIT  = 3;
	// Character and frame lengths
	localparam logic [3:0] DATA_BITS_8  = 4'h8;
	localparam logic [3:0] DATA_BITS_9  = 4'h9;
	localparam logic [3:0] FRAME_BITS_8 = 4'ha;
	localparam logic [3:0] FRAME_BITS_9 = 4'hb;
	// Idle line: a whole frame of high bits counted in receiver samples
	localparam logic [7:0] QUIET_RT_8   = 8'ha0;
	localparam logic [7:0] QUIET_RT_9   = 8'hb0;
	localparam logic [3:0] IDX_START    = 4'h0;
	localparam logic [3:0] IDX_FIRST    = 4'h1;
	localparam logic [10:0] FRAME_ONES  = 11'h7ff;
	localparam logic [10:0] FRAME_ZEROS = 11'h000;
	// Reset values of the transmit flags
	localparam logic TX_EMPTY_RST = 1'b1;
	localparam logic TX_DONE_RST  = 1'b1;

	typedef enum logic {RX_HUNT, RX_FRAME} nspw_rx_e;
	typedef enum logic {TX_IDLE, TX_FRAME} nspw_tx_e;

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Rate select: divide by a power of two
	function automatic logic [6:0] rateMask(input logic [2:0] sel);
		logic [7:0] m;
		m = (8'h01 << sel) - 8'h01;
		rateMask = m[6:0];
	endfunction

	function automatic logic [3:0] frameBits(input logic nine);
		frameBits = nine ? FRAME_BITS_9 : FRAME_BITS_8;
	endfunction

	function automatic logic [3:0] dataBits(input logic nine);
		dataBits = nine ? DATA_BITS_9 : DATA_BITS_8;
	endfunction
endpackage

// [verif/nspw_remote_model.sv]
// Remote serial transceiver model facing the serial port pins
`timescale 1ns/1ps
`default_nettype none
module nspw_remote_model (
	// Clock
	input  wire logic clk,
	// Serial lines
	input  wire logic txLine,
	output logic      rxLine
);
	logic [8:0] gotWord;
	logic       gotStop;
	// Mark level while no frame is sent
	initial rxLine = 1'b1;
	// Bit time is 16 clocks at the rate selects used by the bench
	task automatic sendWord(input logic nine, input logic [8:0] w);
		int i;
		rxLine = 1'b0;
		repeat (16) @(negedge clk);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			rxLine = w[i];
			repeat (16) @(negedge clk);
		end
		rxLine = 1'b1;
		repeat (16) @(negedge clk);
	endtask
	// Samples each bit in its middle; gives up on the start edge after n clocks
	task automatic getWord(input logic nine, input int n);
		int i;
		gotWord = 9'h000;
		for (i = 0; i < n && txLine !== 1'b0; i++) begin
			@(negedge clk);
		end
		repeat (8) @(negedge clk);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			repeat (16) @(negedge clk);
			gotWord[i] = txLine;
		end
		repeat (16) @(negedge clk);
		gotStop = txLine;
	endtask
endmodule
`default_nettype wire

// [verif/nspw_serial_port_test.sv]
// Self-checking bench for the NRZ serial port with wake-up
`timescale 1ns/1ps
`default_nettype none
module nspw_serial_port_test;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic       dataWr = 1'b0, txBit8 = 1'b0, wordNine = 1'b0, wakeAddr = 1'b0, clkPol = 1'b1;
	logic       txOn = 1'b0, rxOn = 1'b0, txIrqEn = 1'b0, doneIrqEn = 1'b0, rxIrqEn = 1'b0;
	logic       idleIrqEn = 1'b0, sleepSetReq = 1'b0, sleepClrReq = 1'b0, breakSend = 1'b0;
	logic       rxFlagsAck = 1'b0, lastBitClk = 1'b0;
	logic [1:0] prescaleSel = 2'h0;
	logic [2:0] txRateSel = 3'h0;
	logic [7:0] dataWrVal = 8'h00;
	logic [7:0] rxData;
	logic       rxBit8, txEmpty, txDone, rxFull, lineQuiet, overrun, noise, framingErr;
	logic       rxSleep, irq, serialIn, serialOut, serialOutEn, syncClk, syncClkEn;
	wire logic  txLine;
	int         nMismatch = 0, checksDone = 0, syncEdges = 0;
	// A released output floats to the pulled-up mark level
	assign txLine = serialOutEn ? serialOut : 1'b1;
	always #25 clk_sys = ~clk_sys;
	always @(posedge syncClk) syncEdges++;
	nspw_serial_port dut (
		.clk_sys, .sys_rst, .dataWr, .dataWrVal, .txBit8, .rxData, .rxBit8, .wordNine,
		.wakeAddr, .clkPol, .clkPha(1'b0), .lastBitClk, .txOn, .rxOn, .txIrqEn,
		.doneIrqEn, .rxIrqEn, .idleIrqEn, .sleepSetReq, .sleepClrReq, .breakSend,
		.prescaleSel, .rxRateSel(3'h0), .txRateSel, .rxFlagsAck, .txEmpty,
		.txDone, .rxFull, .lineQuiet, .overrun, .noise, .framingErr, .rxSleep, .irq,
		.serialIn, .serialOut, .serialOutEn, .syncClk, .syncClkEn
	);
	nspw_remote_model remote (.clk(clk_sys), .txLine(txLine), .rxLine(serialIn));
	task automatic stopTest();
		if (nMismatch == 0 && checksDone > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
		checksDone++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			nMismatch++;
		end
	endtask
	task automatic waitVal(ref logic s, input logic v, input int n);
		int i;
		for (i = 0; i < n && s !== v; i++) begin
			@(negedge clk_sys);
		end
		if (s !== v) begin
			$display("wrong value wait expected %h seen %h", v, s);
			nMismatch++;
			stopTest();
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask
	task automatic sendByte(input logic [8:0] w);
		dataWrVal = w[7:0];
		txBit8 = w[8];
		pulse(dataWr);
	endtask
	task automatic testTx(input logic nine, input logic [8:0] w);
		wordNine = nine;
		syncEdges = 0;
		fork
			remote.getWord(nine, 400);
			begin
				sendByte(w);
				chk("txDone busy", 9'h000, txDone);
			end
		join
		chk("tx word", w, remote.gotWord);
		chk("tx stop", 9'h001, remote.gotStop);
		chk("txEmpty", 9'h001, txEmpty);
		txIrqEn = 1'b1;
		@(negedge clk_sys);
		chk("irq empty", 9'h001, irq);
		txIrqEn = 1'b0;
		waitVal(txDone, 1'b1, 40);
		chk("sync pulses", (nine ? 9'h008 : 9'h007) + {8'h00, lastBitClk}, syncEdges[8:0]);
		doneIrqEn = 1'b1;
		@(negedge clk_sys);
		chk("irq done", 9'h001, irq);
		doneIrqEn = 1'b0;
	endtask
	task automatic testStop();
		wordNine = 1'b0;
		fork
			remote.getWord(1'b0, 400);
			begin
				sendByte(9'h0c3);
				repeat (60) @(negedge clk_sys);
				txOn = 1'b0;
				@(negedge clk_sys);
				chk("outEn held", 9'h001, serialOutEn);
			end
		join
		chk("whole word", 9'h0c3, remote.gotWord);
		waitVal(txDone, 1'b1, 40);
		@(negedge clk_sys);
		chk("outEn off", 9'h000, serialOutEn);
		chk("clkEn off", 9'h000, syncClkEn);
	endtask
	task automatic testRx(input logic nine, input logic [8:0] w);
		wordNine = nine;
		remote.sendWord(nine, w);
		waitVal(rxFull, 1'b1, 40);
		chk("rxData", {1'b0, w[7:0]}, rxData);
		chk("rxBit8", nine & w[8], rxBit8);
		chk("noise", 9'h000, noise);
		chk("framingErr", 9'h000, framingErr);
		chk("overrun", 9'h000, overrun);
		rxIrqEn = 1'b1;
		@(negedge clk_sys);
		chk("irq rx", 9'h001, irq);
		rxIrqEn = 1'b0;
		pulse(rxFlagsAck);
	endtask
	task automatic testQuiet();
		rxOn = 1'b1;
		repeat (300) @(negedge clk_sys);
		chk("quiet early", 9'h000, lineQuiet);
		testRx(1'b0, 9'h03c);
		idleIrqEn = 1'b1;
		waitVal(lineQuiet, 1'b1, 200);
		chk("irq idle", 9'h001, irq);
		idleIrqEn = 1'b0;
		pulse(rxFlagsAck);
	endtask
	task automatic testWake();
		wordNine = 1'b0;
		wakeAddr = 1'b1;
		pulse(sleepSetReq);
		chk("rxSleep set", 9'h001, rxSleep);
		remote.sendWord(1'b0, 9'h012);
		repeat (20) @(negedge clk_sys);
		chk("full asleep", 9'h000, rxFull);
		remote.sendWord(1'b0, 9'h091);
		waitVal(rxSleep, 1'b0, 40);
		chk("wake data", 9'h091, rxData);
		pulse(rxFlagsAck);
		pulse(sleepSetReq);
		pulse(sleepClrReq);
		chk("rxSleep clr", 9'h000, rxSleep);
		// Idle wake: the character at once after sleeping keeps the line busy
		wakeAddr = 1'b0;
		pulse(sleepSetReq);
		remote.sendWord(1'b0, 9'h040);
		repeat (100) @(negedge clk_sys);
		chk("still asleep", 9'h001, rxSleep);
		chk("full asleep", 9'h000, rxFull);
		waitVal(rxSleep, 1'b0, 120);
	endtask
	task automatic testBreak();
		int n;
		wordNine = 1'b1;
		txOn = 1'b1;
		repeat (200) @(negedge clk_sys);
		breakSend = 1'b1;
		waitVal(serialOut, 1'b0, 40);
		n = 0;
		repeat (176) begin
			if (serialOut === 1'b0 && syncClk === clkPol) n++;
			@(negedge clk_sys);
		end
		chk("break low", 9'h0b0, n[8:0]);
		breakSend = 1'b0;
		repeat (400) @(negedge clk_sys);
		chk("line mark", 9'h001, serialOut);
	endtask
	task automatic testRate();
		int n;
		txOn = 1'b0;
		rxOn = 1'b0;
		wordNine = 1'b0;
		waitVal(serialOutEn, 1'b0, 400);
		// Rates change only with both sides off
		prescaleSel = 2'h1;
		txRateSel = 3'h1;
		@(negedge clk_sys);
		txOn = 1'b1;
		sendByte(9'h0ff);
		waitVal(serialOut, 1'b0, 1000);
		n = 0;
		while (serialOut === 1'b0 && n < 200) begin
			n++;
			@(negedge clk_sys);
		end
		chk("bit time", 9'h040, n[8:0]);
	endtask
	initial begin
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		chk("txEmpty rst", 9'h001, txEmpty);
		chk("txDone rst", 9'h001, txDone);
		chk("outEn rst", 9'h000, serialOutEn);
		txOn = 1'b1;
		repeat (200) @(negedge clk_sys);
		chk("sync rest", clkPol, syncClk);
		testTx(1'b0, 9'h0a5);
		testTx(1'b1, 9'h15a);
		lastBitClk = 1'b1;
		testTx(1'b0, 9'h03c);
		lastBitClk = 1'b0;
		testStop();
		testQuiet();
		testRx(1'b1, 9'h1a5);
		testWake();
		testBreak();
		testRate();
		stopTest();
	end
endmodule
`default_nettype wire
